// file: rtl/pcct_params.svh
// Constants for the per-processor clock throttle and sleep-state block.
`ifndef PCCT_PARAMS_SVH
`define PCCT_PARAMS_SVH
`define PCCT_ADDR_W 4
`define PCCT_OFS_CTRL 4'h0
`define PCCT_OFS_C2 4'h4
`define PCCT_OFS_C3 4'h5
`define PCCT_OFS_STAT 4'h8
`define PCCT_OFS_ARB 4'hc
`define PCCT_DUTY_LSB 1
`define PCCT_DUTY_W 3
`define PCCT_THT_BIT 4
`define PCCT_WAKE_BIT 5
`define PCCT_DUTY_RST 3'h4
`define PCCT_STEP_LAST 3'h7
`endif

// file: rtl/pcct_pkg.sv
// Types for the per-processor clock throttle and sleep-state block.
package pcct_pkg;
	typedef enum logic [1:0] {
		PCCT_C0,
		PCCT_C2,
		PCCT_C3
	} pcct_state_t;
endpackage

// file: rtl/pcct_clock_ctrl.sv
// Per-processor clock throttle and C2/C3 sleep control with a Wishbone slave.
// Functional notes
// - Reading C2 entry register enters C2.
// - Reading C3 entry register enters C3.
// - Entry happens exactly on the read.
// - C1 mandatory; C2 and C3 optional here.
// - No instructions executed outside C0.
// - Performance equals duty over eight steps.
// - Stop-clock low periodically halts processor clock.
// - Eight duty levels per eight-step period.
// - One block instance per processor.
// - Leave C1 whenever an interrupt is pending.
// - C1 via halt instruction, no chipset logic.
// - C1 keeps caches intact.
// - Only meaningful in the working system state.
// - C3 helped by activity flag, arbiter disable.
// - Leave C2 on a pending interrupt.
// - Leave C3 on interrupt or bus-master wake.
// - Activity flag set while bus master active.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pcct_params.svh"
module pcct_clock_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PCCT_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic irq_pending_i,
	input wire logic busmaster_active_i,
	input wire logic busmaster_request_i,
	input wire logic system_working_i,
	output logic stop_clock_n_o,
	output logic busmaster_arbiter_disable_o,
	output logic [1:0] cstate_o
);
	// Status pins from outside pass two flops before use; the bus inputs are used directly.
	logic [1:0] irq_sync_reg;
	logic [1:0] bma_sync_reg;
	logic [1:0] bmr_sync_reg;
	logic [1:0] work_sync_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_sync_reg <= 2'h0;
			bma_sync_reg <= 2'h0;
			bmr_sync_reg <= 2'h0;
			work_sync_reg <= 2'h0;
		end else begin
			irq_sync_reg <= {irq_sync_reg[0], irq_pending_i};
			bma_sync_reg <= {bma_sync_reg[0], busmaster_active_i};
			bmr_sync_reg <= {bmr_sync_reg[0], busmaster_request_i};
			work_sync_reg <= {work_sync_reg[0], system_working_i};
		end
	end
	wire irq_s = irq_sync_reg[1];
	wire bma_s = bma_sync_reg[1];
	wire bmr_s = bmr_sync_reg[1];
	wire working_s = work_sync_reg[1];

	// Bus decode.
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd = req & ~wb_we_i;
	wire hit_ctrl = wb_adr_i == `PCCT_OFS_CTRL;
	wire hit_c2 = wb_adr_i == `PCCT_OFS_C2;
	wire hit_c3 = wb_adr_i == `PCCT_OFS_C3;
	wire hit_stat = wb_adr_i == `PCCT_OFS_STAT;
	wire hit_arb = wb_adr_i == `PCCT_OFS_ARB;

	logic [`PCCT_DUTY_W-1:0] duty_reg;
	logic throttle_enable_reg;
	logic busmaster_wake_enable_reg;
	logic busmaster_activity_flag_reg;
	logic busmaster_arbiter_disable_reg;
	pcct_pkg::pcct_state_t state_reg;
	pcct_pkg::pcct_state_t state_next;
	logic [`PCCT_DUTY_W-1:0] step_reg;
	logic stop_n_reg;

	// Control register writes; software keeps the write-order discipline.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty_reg <= `PCCT_DUTY_RST;
			throttle_enable_reg <= 1'b0;
			busmaster_wake_enable_reg <= 1'b0;
			busmaster_arbiter_disable_reg <= 1'b0;
		end else if (wr && hit_ctrl) begin
			duty_reg <= wb_dat_i[`PCCT_DUTY_LSB +: `PCCT_DUTY_W];
			throttle_enable_reg <= wb_dat_i[`PCCT_THT_BIT];
			busmaster_wake_enable_reg <= wb_dat_i[`PCCT_WAKE_BIT];
		end else if (wr && hit_arb) begin
			busmaster_arbiter_disable_reg <= wb_dat_i[0];
		end
	end

	// Activity flag: set wins over a write-one clear in the same cycle.
	wire bm_clear = wr && hit_stat && wb_dat_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busmaster_activity_flag_reg <= 1'b0;
		end else if (bma_s) begin
			busmaster_activity_flag_reg <= 1'b1;
		end else if (bm_clear) begin
			busmaster_activity_flag_reg <= 1'b0;
		end
	end

	// Sleep-state sequencing; C1 is the core's own halt and needs nothing here.
	// One instance serves one processor, so each core gets its own entry registers.
	// C1 entry, exit on interrupt and cache keeping stay inside the core.
	wire enter_c2 = rd && hit_c2 && working_s;
	wire enter_c3 = rd && hit_c3 && working_s;
	wire wake_c3 = irq_s | (busmaster_wake_enable_reg & bmr_s);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pcct_pkg::PCCT_C0: begin
				if (enter_c3) begin
					state_next = pcct_pkg::PCCT_C3;
				end else if (enter_c2) begin
					state_next = pcct_pkg::PCCT_C2;
				end
			end
			pcct_pkg::PCCT_C2: begin
				if (irq_s || !working_s) begin
					state_next = pcct_pkg::PCCT_C0;
				end
			end
			pcct_pkg::PCCT_C3: begin
				if (wake_c3 || !working_s) begin
					state_next = pcct_pkg::PCCT_C0;
				end
			end
			default: state_next = pcct_pkg::PCCT_C0;
		endcase
	end

	// Eight-step throttle period; duty steps of eight run the clock.
	wire throttling = throttle_enable_reg && working_s && state_reg == pcct_pkg::PCCT_C0;
	wire run_step = step_reg < duty_reg;
	wire stop_next = (state_next != pcct_pkg::PCCT_C0) ? 1'b0 : (throttling ? run_step : 1'b1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pcct_pkg::PCCT_C0;
			step_reg <= 3'h0;
			stop_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			step_reg <= throttling ? step_reg + 3'h1 : 3'h0;
			stop_n_reg <= stop_next;
		end
	end

	// Read mux; the entry registers read as zero, their effect is the sequence.
	wire [31:0] ctrl_word = {26'h0, busmaster_wake_enable_reg, throttle_enable_reg, duty_reg, 1'b0};
	wire [31:0] stat_word = {29'h0, state_reg, busmaster_activity_flag_reg};
	wire [31:0] rd_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word : hit_arb ? {31'h0, busmaster_arbiter_disable_reg} : 32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_clock_n_o <= 1'b1;
			busmaster_arbiter_disable_o <= 1'b0;
			cstate_o <= 2'h0;
		end else begin
			stop_clock_n_o <= stop_n_reg;
			busmaster_arbiter_disable_o <= busmaster_arbiter_disable_reg;
			cstate_o <= state_reg;
		end
	end
endmodule
`default_nettype wire

// file: dv/pcct_core_model.sv
// Core model that counts the clock cycles its stop-clock input lets through.
`timescale 1ns/10ps
`default_nettype none
module pcct_core_model (
	input wire logic clk_i,
	input wire logic stop_clock_n_i,
	output var int runs_o
);
	initial runs_o = 0;
	// The core steps only while its clock is not held stopped.
	always @(posedge clk_i) if (stop_clock_n_i) runs_o <= runs_o + 1;
endmodule
`default_nettype wire

// file: dv/pcct_clock_ctrl_assertions.sv
// Port assertions for the clock control block.
`timescale 1ns/10ps
`default_nettype none
`include "pcct_params.svh"
module pcct_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PCCT_ADDR_W-1:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic irq_pending_i,
	input wire logic system_working_i,
	input wire logic stop_clock_n_o,
	input wire logic [1:0] cstate_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire c0 = cstate_o == 2'h0;
	wire rd = tk && !wb_we_i && c0 && !irq_pending_i && system_working_i;
	ack_given_a: assert property (tk |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	c2_entry_a: assert property (rd && wb_adr_i == `PCCT_OFS_C2 |-> ##[1:4] cstate_o == 2'h1) else $error("no c2");
	c3_entry_a: assert property (rd && wb_adr_i == `PCCT_OFS_C3 |-> ##[1:4] cstate_o == 2'h2) else $error("no c3");
	write_idle_a: assert property (tk && wb_we_i && c0 |=> c0 [*4]) else $error("write slept");
	sleep_stop_a: assert property (!c0 |-> !stop_clock_n_o) else $error("clock ran");
	irq_wake_a: assert property ((!c0 && irq_pending_i) [*3] |-> ##[0:6] c0) else $error("no wake");
	work_loss_a: assert property (!system_working_i [*3] |-> ##[0:6] c0) else $error("slept off s0");
	cover property (cstate_o == 2'h1);
	cover property (cstate_o == 2'h2);
	cover property ($rose(irq_pending_i));
endmodule
bind pcct_clock_ctrl pcct_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .irq_pending_i(irq_pending_i),
	.system_working_i(system_working_i), .stop_clock_n_o(stop_clock_n_o), .cstate_o(cstate_o));
`default_nettype wire

// file: dv/test_pcct_clock_ctrl.sv
// Self-checking bench for the clock control block.
`timescale 1ns/10ps
`default_nettype none
module test_pcct_clock_ctrl;
	logic clk = 0, rst = 1, cyc = 0, we = 0, irq = 0, bma = 0, bmr = 0, wk = 1, ack, stp, arb;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [1:0] cs;
	int failures = 0, n_compared = 0, r0, runs, v;
	always #2 clk = ~clk;
	pcct_clock_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_pending_i(irq),
		.busmaster_active_i(bma), .busmaster_request_i(bmr), .system_working_i(wk), .stop_clock_n_o(stp),
		.busmaster_arbiter_disable_o(arb), .cstate_o(cs));
	pcct_core_model core (.clk_i(clk), .stop_clock_n_i(stp), .runs_o(runs));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		tick(1);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do tick(1); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
	endtask
	// Any 8n-cycle window of an eight-step period holds the same number of running steps.
	function automatic int on_steps(input int d, input int n);
		return d * n / 8;
	endfunction
	task automatic test_done;
		if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		v = $urandom(14753);
		tick(3);
		rst <= 0;
		for (int d = 1; d < 8; d++) begin
			wb(1, 0, d * 2);
			wb(1, 0, d * 2 + 16);
			tick(8 + $urandom % 8);
			r0 = runs;
			tick(64);
			chk("duty", on_steps(d, 64), runs - r0);
			wb(1, 0, d * 2);
		end
		tick(4);
		r0 = runs;
		tick(16);
		chk("run", 16, runs - r0);
		wb(1, 4, 0);
		tick(3);
		wb(0, 4, 0);
		tick(4);
		chk("c2", 1, cs);
		irq <= 1;
		tick(8);
		chk("irq", 0, cs);
		irq <= 0;
		wb(1, 0, 32'h28);
		tick(3);
		wb(0, 5, 0);
		tick(4);
		chk("c3", 2, cs);
		bmr <= 1;
		bma <= 1;
		tick(8);
		chk("bm", 0, cs);
		wb(0, 8, 0);
		chk("act", 1, q[0]);
		v = $urandom % 2;
		wb(1, 12, v);
		tick(2);
		chk("arb", v, arb);
		wb(0, 4, 0);
		wk <= 0;
		tick(8);
		chk("s0", 0, cs);
		test_done;
	end
	initial begin
		tick(5000);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire
